// ==== rtl/scc_pkg.sv ====
// Constants and types of the surge comparator control block
package scc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] SCC_IDX_FILTER_REF = 10'h09a;
  localparam logic [9:0] SCC_IDX_MODE       = 10'h09d;
  localparam logic [9:0] SCC_IDX_IRQ_STATUS = 10'h0a0;
  localparam logic [9:0] SCC_IDX_IRQ_MASK   = 10'h0a1;
  localparam logic [9:0] SCC_IDX_PULSE_CTRL = 10'h0a2;

  // comparator_mode fields
  localparam int SCC_MODE_EN_BIT     = 7;
  localparam int SCC_MODE_OEN_BIT    = 6;
  localparam int SCC_MODE_RAW_BIT    = 5;
  localparam int SCC_MODE_SURGE_BIT  = 4;
  localparam int SCC_MODE_EDGE_BIT   = 3;
  localparam int SCC_MODE_REF_LSB    = 0;
  localparam logic [7:0] SCC_MODE_RESET = 8'h00;

  // comparator_filter_ref fields
  localparam int SCC_FR_SRC_BIT = 2;
  localparam int SCC_FR_DB_LSB  = 0;
  localparam logic [2:0] SCC_FR_RESET = 3'h0;

  // Status and mask fields
  localparam int SCC_ST_EVENT_BIT = 0;
  localparam int SCC_ST_SURGE_BIT = 1;
  localparam logic [1:0] SCC_ST_RESET   = 2'h0;
  localparam logic [1:0] SCC_MASK_RESET = 2'h0;

  // pulse_ctrl fields
  localparam int SCC_PC_OUT_BIT   = 0;
  localparam int SCC_PC_TMR_BIT   = 1;
  localparam int SCC_PC_CMP0_BIT  = 2;
  localparam int SCC_PC_HOLD_BIT  = 3;
  localparam logic [2:0] SCC_PC_RESET = 3'h0;

  // Debounce lengths in cpu cycles for codes 01, 10, 11
  localparam logic [2:0] SCC_DB_CYC_1 = 3'h1;
  localparam logic [2:0] SCC_DB_CYC_2 = 3'h2;
  localparam logic [2:0] SCC_DB_CYC_3 = 3'h4;

  typedef enum logic [1:0] {
    SCC_ST_IDLE = 2'b01,
    SCC_ST_ACK  = 2'b10
  } scc_apb_e;

  typedef struct packed {
    scc_apb_e    st;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [7:0]  mode;
    logic [2:0]  filt_ref;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [2:0]  pulse;
    logic        hold;
    logic        hold_lvl;
    logic        raw;
    logic        filt;
    logic [2:0]  cnt;
    logic        irq;
    logic        res_oe;
    logic        res_out;
  } scc_state_s;

endpackage

// ==== rtl/scc_core.sv ====
// Surge comparator control: registers, debounce, edge trigger, surge stop
// Notes on behaviour
// - Enabling the comparator routes the negative pin to it and isolates GPIO; disabled, all pins are GPIO.
// - The result pin carries the comparator result only when enable and output enable are both set.
// - The raw result flag is an unlatched copy of the comparator output and reads 0 while disabled.
// - Edge select 0 triggers on a falling result, 1 on a rising result.
// - Edge detection works on the debounced result, not on the raw comparator output.
// - A trigger sets the event request flag, which stays set until software clears it.
// - With the interrupt enabled, a set event request flag raises the interrupt request.
// - The debounce code selects none, one, two or four cpu cycles.
// - The reference level code selects one of eight taps from the lowest to the highest.
// - The reference source bit selects device supply (0) or the internal 4V reference (1).
// - In surge mode with pulse output enabled, a trigger stops the pulse timer.
// - A surge stop clears pulse output enable, pulse timer enable and comparator 0 trigger mode.
// - After a surge stop the pulse pin becomes GPIO and holds the level it had.
// - A surge stop also sets the event request flag.
// - In green mode events are still latched but the interrupt does not wake the system.
`timescale 1ns/1ps
`default_nettype none

module scc_core
  import scc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        cmp_raw,
  input  wire logic        pulse_pin_level,
  input  wire logic        green_mode,
  output logic             cmp_enable,
  output logic             neg_pin_analog_sel,
  output logic             result_pin_oe,
  output logic             result_pin_out,
  output logic [2:0]       ref_level_select,
  output logic             ref_source_select,
  output logic             pulse_out_enable,
  output logic             pulse_timer_enable,
  output logic             cmp0_trigger_mode,
  output logic             pulse_pin_gpio_hold,
  output logic             pulse_pin_hold_level,
  output logic             irq
);

  scc_state_s s_q;
  scc_state_s s_d;

  logic [9:0]  idx;
  logic        hit;
  logic        acc;
  logic [31:0] rdata;
  logic [2:0]  db_len;
  logic        trig;
  logic        surge;
  logic [1:0]  st_clr;
  logic [2:0]  cnt_inc;

  always_comb begin
    s_d     = s_q;
    idx     = paddr[11:2];
    acc     = psel && penable && s_q.pready;
    trig    = 1'b0;
    surge   = 1'b0;
    st_clr  = 2'h0;
    cnt_inc = 3'(s_q.cnt + 3'h1);
    hit     = (idx == SCC_IDX_FILTER_REF) || (idx == SCC_IDX_MODE) ||
              (idx == SCC_IDX_IRQ_STATUS) || (idx == SCC_IDX_IRQ_MASK) ||
              (idx == SCC_IDX_PULSE_CTRL);

    rdata = 32'h0000_0000;
    case (idx)
      SCC_IDX_MODE: begin
        rdata[7:0] = s_q.mode;
        rdata[SCC_MODE_RAW_BIT] = s_q.raw;
      end
      SCC_IDX_FILTER_REF: rdata[2:0] = s_q.filt_ref;
      SCC_IDX_IRQ_STATUS: rdata[1:0] = s_q.status;
      SCC_IDX_IRQ_MASK:   rdata[1:0] = s_q.mask;
      SCC_IDX_PULSE_CTRL: rdata[3:0] = {s_q.hold, s_q.pulse};
      default:            rdata = 32'h0000_0000;
    endcase

    // One wait state: data captured in the first access cycle
    case (s_q.st)
      SCC_ST_IDLE: begin
        if (psel && penable) begin
          s_d.st      = SCC_ST_ACK;
          s_d.pready  = 1'b1;
          s_d.pslverr = !hit;
          s_d.prdata  = pwrite ? 32'h0000_0000 : rdata;
        end
      end
      SCC_ST_ACK: begin
        s_d.st      = SCC_ST_IDLE;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.prdata  = 32'h0000_0000;
      end
      default: begin
        s_d.st      = SCC_ST_IDLE;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.prdata  = 32'h0000_0000;
      end
    endcase

    if (acc && pwrite) begin
      case (idx)
        SCC_IDX_MODE: begin
          s_d.mode = pwdata[7:0];
          s_d.mode[SCC_MODE_RAW_BIT] = 1'b0;
        end
        SCC_IDX_FILTER_REF: s_d.filt_ref = pwdata[2:0];
        SCC_IDX_IRQ_MASK:   s_d.mask = pwdata[1:0];
        SCC_IDX_PULSE_CTRL: begin
          s_d.pulse = pwdata[2:0];
          // re-arm by software releases the pin hold
          if (pwdata[SCC_PC_OUT_BIT]) begin
            s_d.hold = 1'b0;
          end
        end
        default: s_d.mode = s_d.mode;
      endcase
    end

    // Only the bits actually returned by the read are cleared
    if (acc && !pwrite && idx == SCC_IDX_IRQ_STATUS) begin
      st_clr = s_q.prdata[1:0];
    end

    case (s_q.filt_ref[1:0])
      2'b01:   db_len = SCC_DB_CYC_1;
      2'b10:   db_len = SCC_DB_CYC_2;
      2'b11:   db_len = SCC_DB_CYC_3;
      default: db_len = 3'h0;
    endcase

    s_d.raw = s_q.mode[SCC_MODE_EN_BIT] && cmp_raw;

    if (!s_q.mode[SCC_MODE_EN_BIT]) begin
      s_d.filt = 1'b0;
      s_d.cnt  = 3'h0;
    end else if (db_len == 3'h0) begin
      s_d.filt = s_d.raw;
      s_d.cnt  = 3'h0;
    end else if (s_q.raw != s_q.filt) begin
      if (cnt_inc >= db_len) begin
        s_d.filt = s_q.raw;
        s_d.cnt  = 3'h0;
      end else begin
        s_d.cnt  = cnt_inc;
      end
    end else begin
      s_d.cnt = 3'h0;
    end

    trig = s_q.mode[SCC_MODE_EN_BIT] && (s_d.filt != s_q.filt) &&
           (s_d.filt == s_q.mode[SCC_MODE_EDGE_BIT]);

    surge = trig && s_q.mode[SCC_MODE_SURGE_BIT] &&
            s_q.pulse[SCC_PC_OUT_BIT];

    if (surge) begin
      // protection wins over a same-cycle software write
      s_d.pulse    = 3'h0;
      // pin held as GPIO at its present level
      s_d.hold     = 1'b1;
      s_d.hold_lvl = pulse_pin_level;
    end

    // sticky flags, set wins over clear
    s_d.status = (s_q.status & ~st_clr) | {surge, trig};

    // interrupt, held off in green mode
    s_d.irq = (|(s_d.status & s_d.mask)) && !green_mode;

    s_d.res_oe  = s_q.mode[SCC_MODE_EN_BIT] && s_q.mode[SCC_MODE_OEN_BIT];
    s_d.res_out = s_d.res_oe && s_d.raw;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.st       <= SCC_ST_IDLE;
      s_q.pready   <= 1'b0;
      s_q.pslverr  <= 1'b0;
      s_q.prdata   <= 32'h0000_0000;
      s_q.mode     <= SCC_MODE_RESET;
      s_q.filt_ref <= SCC_FR_RESET;
      s_q.status   <= SCC_ST_RESET;
      s_q.mask     <= SCC_MASK_RESET;
      s_q.pulse    <= SCC_PC_RESET;
      s_q.hold     <= 1'b0;
      s_q.hold_lvl <= 1'b0;
      s_q.raw      <= 1'b0;
      s_q.filt     <= 1'b0;
      s_q.cnt      <= 3'h0;
      s_q.irq      <= 1'b0;
      s_q.res_oe   <= 1'b0;
      s_q.res_out  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready               = s_q.pready;
  assign pslverr              = s_q.pslverr;
  assign prdata               = s_q.prdata;
  // analog enable and negative pin routing
  assign cmp_enable           = s_q.mode[SCC_MODE_EN_BIT];
  assign neg_pin_analog_sel   = s_q.mode[SCC_MODE_EN_BIT];
  assign result_pin_oe        = s_q.res_oe;
  assign result_pin_out       = s_q.res_out;
  assign ref_level_select     = s_q.mode[SCC_MODE_REF_LSB +: 3];
  assign ref_source_select    = s_q.filt_ref[SCC_FR_SRC_BIT];
  assign pulse_out_enable     = s_q.pulse[SCC_PC_OUT_BIT];
  assign pulse_timer_enable   = s_q.pulse[SCC_PC_TMR_BIT];
  assign cmp0_trigger_mode    = s_q.pulse[SCC_PC_CMP0_BIT];
  assign pulse_pin_gpio_hold  = s_q.hold;
  assign pulse_pin_hold_level = s_q.hold_lvl;
  assign irq                  = s_q.irq;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_surge_trip;
    surge;
  endsequence

  sequence s_pulse_off;
    !pulse_out_enable && !pulse_timer_enable && !cmp0_trigger_mode;
  endsequence

  a_gpio_when_off: assert property (
    !cmp_enable |-> ##1 (!result_pin_oe && !s_q.raw))
    else $error("pins not GPIO while comparator disabled");

  a_result_pin: assert property (
    result_pin_oe |-> (result_pin_out == s_q.raw))
    else $error("result pin differs from comparator result");

  a_raw_copy: assert property (
    s_q.raw == $past(cmp_enable && cmp_raw))
    else $error("raw flag is not a copy of comparator output");

  a_edge_dir: assert property (
    trig |-> (s_d.filt == s_q.mode[SCC_MODE_EDGE_BIT]) &&
             (s_q.filt != s_q.mode[SCC_MODE_EDGE_BIT]))
    else $error("trigger on wrong edge direction");

  a_flag_sticky: assert property (
    s_q.status[SCC_ST_EVENT_BIT] && !acc |=> s_q.status[SCC_ST_EVENT_BIT])
    else $error("event flag dropped without software clear");

  a_flag_set: assert property (
    trig |=> s_q.status[SCC_ST_EVENT_BIT])
    else $error("trigger did not set event flag");

  a_irq_raise: assert property (
    trig && s_d.mask[SCC_ST_EVENT_BIT] && !green_mode |=> irq)
    else $error("interrupt not raised for enabled event");

  a_debounce_four: assert property (
    $rose(s_q.filt) && s_q.filt_ref[1:0] == 2'b11 &&
    $past(s_q.filt_ref[1:0]) == 2'b11 |->
    $past(s_q.raw, 1) && $past(s_q.raw, 2) &&
    $past(s_q.raw, 3) && $past(s_q.raw, 4))
    else $error("filtered rise before four stable cycles");

  a_debounce_none: assert property (
    cmp_enable && $past(cmp_enable) && s_q.filt_ref[1:0] == 2'b00 &&
    $past(s_q.filt_ref[1:0]) == 2'b00 |-> s_q.filt == s_q.raw)
    else $error("filter delays result with debounce off");

  a_surge_stop: assert property (
    s_surge_trip |=> s_pulse_off)
    else $error("pulse bits not cleared on surge stop");

  a_surge_hold: assert property (
    s_surge_trip |=> pulse_pin_gpio_hold &&
                     pulse_pin_hold_level == $past(pulse_pin_level))
    else $error("pulse pin not held after surge stop");

  a_surge_flag: assert property (
    s_surge_trip |=> s_q.status == 2'b11)
    else $error("surge stop did not set flags");

  a_no_restore: assert property (
    !pulse_out_enable && !(acc && pwrite) |=> !pulse_out_enable)
    else $error("pulse output re-enabled by hardware");

  a_green_quiet: assert property (
    green_mode |=> !irq)
    else $error("interrupt raised in green mode");

endmodule

`default_nettype wire

// ==== dv/scc_far_model.sv ====
// Far-side model: comparator core output and pulse timer pin
`timescale 1ns/1ps
`default_nettype none
module scc_far_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic level,
  input  wire logic cmp_enable,
  input  wire logic pulse_out_enable,
  input  wire logic pulse_timer_enable,
  output logic      cmp_raw,
  output logic      pulse_pin_level
);
  logic [1:0] div_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_raw         <= 1'b0;
      pulse_pin_level <= 1'b0;
      div_q           <= 2'h0;
    end else begin
      // A disabled core gives no defined result, so it toggles
      cmp_raw <= cmp_enable ? level : ~cmp_raw;
      div_q   <= div_q + 2'h1;
      // Pin toggles every four cycles only while the timer runs
      if (pulse_out_enable && pulse_timer_enable && div_q == 2'h3) begin
        pulse_pin_level <= ~pulse_pin_level;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/scc_core_tb.sv ====
// Self-checking bench of the surge comparator control block
`timescale 1ns/1ps
`default_nettype none
module scc_core_tb;
  import scc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, level, green_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic        pready, pslverr, cmp_raw, pulse_pin_level, cmp_enable;
  logic        neg_sel, res_oe, res_out, ref_src, p_out, p_tmr, p_cmp0;
  logic        p_hold, p_lvl, irq;
  logic [2:0]  ref_lvl, db_n, r;
  logic [32:0] eq[$];
  int          n_fail, n_tests, i;
  logic        lvl_at_stop;

  scc_core i_scc_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .cmp_raw(cmp_raw), .pulse_pin_level(pulse_pin_level),
    .green_mode(green_mode), .cmp_enable(cmp_enable),
    .neg_pin_analog_sel(neg_sel), .result_pin_oe(res_oe),
    .result_pin_out(res_out), .ref_level_select(ref_lvl),
    .ref_source_select(ref_src), .pulse_out_enable(p_out),
    .pulse_timer_enable(p_tmr), .cmp0_trigger_mode(p_cmp0),
    .pulse_pin_gpio_hold(p_hold), .pulse_pin_hold_level(p_lvl), .irq(irq));
  scc_far_model i_scc_far_model (.pclk(pclk), .presetn(presetn),
    .level(level), .cmp_enable(cmp_enable), .pulse_out_enable(p_out),
    .pulse_timer_enable(p_tmr), .cmp_raw(cmp_raw),
    .pulse_pin_level(pulse_pin_level));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input string n, input logic [32:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Reads note {pslverr, prdata} expected; the monitor compares it
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [31:0] d, input logic [32:0] e);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w;
    paddr <= {idx, 2'b00}; pwdata <= d;
    if (!w) eq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!pready && k < 20);
    if (k == 20) begin
      n_fail++;
      finish_test();
    end
    psel <= 1'b0; penable <= 1'b0;
    // Let the commit edge pass so callers see settled outputs
    @(posedge pclk);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [32:0] e);
    apb(1'b0, idx, 32'h0, e);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 33'h0);
  endtask

  // Pin level that stood while the pulse output was last enabled
  always @(posedge pclk) begin
    if (p_out) begin
      lvl_at_stop = pulse_pin_level;
    end
  end

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      chk("prdata", {pslverr, prdata}, eq.pop_front());
    end
  end

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    finish_test();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; level = 1'b0; green_mode = 1'b0;
    seed = 32'hb15132bb; n_fail = 0; n_tests = 0; lvl_at_stop = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(SCC_IDX_MODE, 33'h0);
    rd(SCC_IDX_FILTER_REF, 33'h0);
    rd(SCC_IDX_IRQ_STATUS, 33'h0);
    rd(SCC_IDX_IRQ_MASK, 33'h0);
    rd(SCC_IDX_PULSE_CTRL, 33'h0);
    rd(10'h3ff, 33'h1_0000_0000);
    // every reference tap reaches the ladder
    for (i = 0; i < 8; i++) begin
      wr(SCC_IDX_MODE, 32'(i));
      chk("ref_level", 33'(ref_lvl), 33'(i));
    end
    level <= 1'b1;
    wr(SCC_IDX_MODE, 32'hc0);
    repeat (4) @(posedge pclk);
    rd(SCC_IDX_MODE, 33'he0);
    chk("neg_sel", 33'(neg_sel), 33'h1);
    chk("res_pin", 33'({res_oe, res_out}), 33'h3);
    wr(SCC_IDX_MODE, 32'h80);
    // Result pin enable follows the mode register one cycle later
    @(posedge pclk);
    chk("res_oe", 33'(res_oe), 33'h0);
    wr(SCC_IDX_MODE, 32'h00);
    rd(SCC_IDX_MODE, 33'h00);
    chk("neg_sel", 33'({cmp_enable, neg_sel}), 33'h0);
    wr(SCC_IDX_IRQ_MASK, 32'h1);
    // each debounce code; glitches shorter than it are dropped
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      r = seed[2:0];
      db_n = (i == 3) ? 3'h4 : 3'(i);
      wr(SCC_IDX_FILTER_REF, {29'h0, seed[3], 2'(i)});
      chk("ref_src", 33'(ref_src), 33'(seed[3]));
      wr(SCC_IDX_MODE, {24'h0, 4'hc, 1'(i), r});
      chk("ref_level", 33'(ref_lvl), 33'(r));
      repeat (8) @(posedge pclk);
      rd(SCC_IDX_IRQ_STATUS, 33'h0);
      if (db_n > 3'h1) begin
        level <= i[0];
        repeat (db_n - 3'h1) @(posedge pclk);
        level <= ~i[0];
      end
      repeat (8) @(posedge pclk);
      rd(SCC_IDX_IRQ_STATUS, 33'h0);
      level <= i[0];
      repeat (8) @(posedge pclk);
      chk("irq", 33'(irq), 33'h1);
      rd(SCC_IDX_IRQ_STATUS, 33'h1);
      repeat (2) @(posedge pclk);
      chk("irq", 33'(irq), 33'h0);
    end
    // green mode latches the event but holds the interrupt back
    level <= 1'b0;
    green_mode <= 1'b1;
    repeat (8) @(posedge pclk);
    level <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("irq", 33'(irq), 33'h0);
    green_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("irq", 33'(irq), 33'h1);
    rd(SCC_IDX_IRQ_STATUS, 33'h1);
    wr(SCC_IDX_IRQ_MASK, 32'h0);
    wr(SCC_IDX_PULSE_CTRL, 32'h7);
    wr(SCC_IDX_MODE, 32'h98);
    level <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(SCC_IDX_IRQ_STATUS, 33'h0);
    level <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("pulse", 33'({p_out, p_tmr, p_cmp0}), 33'h0);
    chk("hold", 33'({p_hold, p_lvl}), 33'({1'b1, lvl_at_stop}));
    chk("irq", 33'(irq), 33'h0);
    rd(SCC_IDX_IRQ_STATUS, 33'h3);
    rd(SCC_IDX_PULSE_CTRL, 33'h8);
    // software alone restarts the pulse timer
    wr(SCC_IDX_PULSE_CTRL, 32'h7);
    chk("resume", 33'({p_out, p_tmr, p_cmp0, p_hold}), 33'he);
    finish_test();
  end
endmodule
`default_nettype wire
